// ===== itp_defines.vh
/*
  Constants for the three-channel interval timer: host port
  addresses, control word fields, access orders and mode codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef ITP_DEFINES_VH
`define ITP_DEFINES_VH

// Host port addresses on the two select lines
`define ITP_PORT_CNT0      2'h0
`define ITP_PORT_CNT1      2'h1
`define ITP_PORT_CNT2      2'h2
`define ITP_PORT_CTRL      2'h3

// Control word field positions
`define ITP_CW_PICK_HI     7
`define ITP_CW_PICK_LO     6
`define ITP_CW_ORDER_HI    5
`define ITP_CW_ORDER_LO    4
`define ITP_CW_MODE_HI     3
`define ITP_CW_MODE_LO     1
`define ITP_CW_BCD         0

// Counter pick value that selects no counter
`define ITP_PICK_NONE      2'h3

// Byte order field codes
`define ITP_ORD_LATCH      2'h0
`define ITP_ORD_LSB        2'h1
`define ITP_ORD_MSB        2'h2
`define ITP_ORD_BOTH       2'h3

// Operating mode codes after folding
`define ITP_MODE_TC_INT    3'h0
`define ITP_MODE_ONESHOT   3'h1
`define ITP_MODE_RATE      3'h2
`define ITP_MODE_SQUARE    3'h3
`define ITP_MODE_SW_STROBE 3'h4
`define ITP_MODE_HW_STROBE 3'h5

// Reset values
`define ITP_RST_MODE       3'h0
`define ITP_RST_ORDER      2'h3
`define ITP_RST_COUNT      16'h0000

// Pin synchroniser depth
`define ITP_SYNC_DEPTH     3

`endif

// ===== itp_pin_sync.v
/*
  Pin synchroniser: each bit passes three flip-flops and its
  filtered value changes once the second and third stages agree.
  Assumes pins are asynchronous to clock.
*/
`timescale 1ns/10ps
`include "itp_defines.vh"

module itp_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_filt
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg [`ITP_SYNC_DEPTH-1:0] stage_reg;
      reg                       filt_reg;
      always @(posedge clock) begin
        if (rst) begin
          stage_reg <= {`ITP_SYNC_DEPTH{RST_VAL[i]}};
          filt_reg  <= RST_VAL[i];
        end else begin
          stage_reg <= {stage_reg[`ITP_SYNC_DEPTH-2:0], pin_in[i]};
          if (stage_reg[1] == stage_reg[2]) begin
            filt_reg <= stage_reg[2];
          end
        end
      end
      assign pin_filt[i] = filt_reg;
    end
  endgenerate

endmodule

// ===== itp_top.v
/*
  Three-channel programmable interval timer with its host port:
  select, strobes, two port selects and an 8-bit three-state data
  path; three 16-bit down counters with own clock, gate and output.
  Assumes all pins are asynchronous to clock; the data pin wire is
  resolved outside from data_out and data_oe.
*/
`timescale 1ns/10ps
`include "itp_defines.vh"

// What this block does
// - Deselected: ignore access, release data bus
// - Select gates host access only
// - 8-bit three-state host data path
// - Write at ports 0-2 loads count byte
// - Read at ports 0-2 returns count byte
// - Write at port 3 stores control word
// - Control port read is no-op, bus released
// - Control word sets mode, base, load order
// - Each channel has 16-bit presettable down counter
// - Binary or decimal counting per channel
// - Channels identical and independent
// - Counter readable while running
// - Exactly four host ports
// - Control fields: pick, mode, base
// - Byte order field: latch, lsb, msb, both
// - Count loads after rise then fall
module itp_top (
  input  wire       clock,
  input  wire       rst,
  input  wire       cs_n,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire       port_select_lo,
  input  wire       port_select_hi,
  input  wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire       data_oe,
  input  wire [2:0] count_clk,
  input  wire [2:0] count_gate,
  output wire [2:0] count_out
);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [18:0] pins_filt;
  wire        cs_f;
  wire        rd_f;
  wire        wr_f;
  wire [1:0]  addr_f;
  wire [7:0]  data_f;
  wire [2:0]  clk_f;
  wire [2:0]  gate_f;

  itp_pin_sync #(
    .WIDTH   (19),
    .RST_VAL ({6'h00, 8'h00, 2'h0, 3'h7})
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .pin_in   ({count_gate, count_clk, data_in,
                port_select_hi, port_select_lo, wr_n, rd_n, cs_n}),
    .pin_filt (pins_filt)
  );

  assign cs_f   = pins_filt[0];
  assign rd_f   = pins_filt[1];
  assign wr_f   = pins_filt[2];
  assign addr_f = pins_filt[4:3];
  assign data_f = pins_filt[12:5];
  assign clk_f  = pins_filt[15:13];
  assign gate_f = pins_filt[18:16];

  ////////////////////////////////////////////////////////////////
  // Decode functions
  function port_hit;
    input [1:0] a;
    input [1:0] n;
    begin
      port_hit = (a == n);
    end
  endfunction

  function [15:0] dec1;
    input [15:0] v;
    input        b;
    reg   [15:0] r;
    reg          brw;
    integer      k;
    begin
      r   = v;
      brw = 1'b1;
      if (b) begin
        for (k = 0; k < 4; k = k + 1) begin
          if (brw) begin
            if (r[k*4 +: 4] == 4'h0) begin
              r[k*4 +: 4] = 4'h9;
            end else begin
              r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
              brw = 1'b0;
            end
          end
        end
      end else begin
        r = v - 16'h0001;
      end
      dec1 = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Host access state machine
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WR   = 3'b010;
  localparam [2:0] ST_RD   = 3'b100;

  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [1:0] addr_reg;
  reg  [7:0] wdata_reg;
  reg  [7:0] data_out_reg;
  wire       sel;
  wire       wr_commit;
  wire       rd_done;

  assign sel       = ~cs_f;
  assign wr_commit = state_reg[2'd1] & wr_f & sel;
  assign rd_done   = state_reg[2'd2] & rd_f & sel;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sel & ~wr_f & rd_f) begin
          state_next = ST_WR;
        end else if (sel & ~rd_f & wr_f) begin
          state_next = ST_RD;
        end
      end
      ST_WR: begin
        if (wr_f | ~sel) begin
          state_next = ST_IDLE;
        end
      end
      ST_RD: begin
        if (rd_f | ~sel) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      addr_reg  <= 2'h0;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE) begin
        addr_reg <= addr_f;
      end
      if (~wr_f) begin
        wdata_reg <= data_f;
      end
    end
  end

  // Bus driven only during a selected read of a counter port
  assign data_oe = state_reg[2'd2] & sel & ~rd_f & wr_f &
                   ~port_hit(addr_reg, `ITP_PORT_CTRL);
  assign data_out = data_out_reg;

  wire        ctl_wr;
  wire [1:0]  cw_pick;
  wire [23:0] chan_bytes;

  assign ctl_wr  = wr_commit & port_hit(addr_reg, `ITP_PORT_CTRL);
  assign cw_pick = wdata_reg[`ITP_CW_PICK_HI:`ITP_CW_PICK_LO];

  always @(posedge clock) begin
    if (rst) begin
      data_out_reg <= 8'h00;
    end else begin
      case (addr_reg)
        `ITP_PORT_CNT0: data_out_reg <= chan_bytes[7:0];
        `ITP_PORT_CNT1: data_out_reg <= chan_bytes[15:8];
        `ITP_PORT_CNT2: data_out_reg <= chan_bytes[23:16];
        default:        data_out_reg <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Counter channels
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_chan
      localparam [31:0] CH_NUM = c;
      reg  [2:0]  mode_reg;
      reg         bcd_reg;
      reg  [1:0]  order_reg;
      reg  [15:0] init_reg;
      reg  [15:0] cnt_reg;
      reg  [15:0] latch_reg;
      reg         latched_reg;
      reg         wr_hi_reg;
      reg         rd_hi_reg;
      reg         pend_reg;
      reg         armed_reg;
      reg         run_reg;
      reg         out_reg;
      reg         trig_reg;
      reg         clk_q;
      reg         gate_q;
      wire        rise;
      wire        fall;
      wire        g_rise;
      wire        cnt_wr;
      wire        cw_hit;
      wire        rd_hit;
      wire [2:0]  cw_mode;
      wire [15:0] src;
      wire [15:0] step1;
      wire [15:0] step2;

      assign rise   = clk_f[c] & ~clk_q;
      assign fall   = ~clk_f[c] & clk_q;
      assign g_rise = gate_f[c] & ~gate_q;
      assign cnt_wr = wr_commit & port_hit(addr_reg, CH_NUM[1:0]);
      assign cw_hit = ctl_wr & port_hit(cw_pick, CH_NUM[1:0]);
      assign rd_hit = rd_done & port_hit(addr_reg, CH_NUM[1:0]);
      assign cw_mode = wdata_reg[2] ? {1'b0, wdata_reg[2:1]} :
                       wdata_reg[3:1];
      assign step1 = dec1(cnt_reg, bcd_reg);
      assign step2 = dec1(step1, bcd_reg);
      assign src   = latched_reg ? latch_reg : cnt_reg;

      assign chan_bytes[c*8 +: 8] =
        (order_reg == `ITP_ORD_MSB) ? src[15:8] :
        (order_reg == `ITP_ORD_LSB) ? src[7:0] :
        (rd_hi_reg ? src[15:8] : src[7:0]);
      assign count_out[c] = out_reg;

      always @(posedge clock) begin
        if (rst) begin
          mode_reg    <= `ITP_RST_MODE;
          bcd_reg     <= 1'b0;
          order_reg   <= `ITP_RST_ORDER;
          init_reg    <= `ITP_RST_COUNT;
          cnt_reg     <= `ITP_RST_COUNT;
          latch_reg   <= `ITP_RST_COUNT;
          latched_reg <= 1'b0;
          wr_hi_reg   <= 1'b0;
          rd_hi_reg   <= 1'b0;
          pend_reg    <= 1'b0;
          armed_reg   <= 1'b0;
          run_reg     <= 1'b0;
          out_reg     <= 1'b0;
          trig_reg    <= 1'b0;
          clk_q       <= 1'b0;
          gate_q      <= 1'b0;
        end else begin
          // Counting runs whatever the host select does
          clk_q  <= clk_f[c];
          gate_q <= gate_f[c];
          if (pend_reg & rise) begin
            armed_reg <= 1'b1;
          end
          if ((mode_reg == `ITP_MODE_RATE ||
               mode_reg == `ITP_MODE_SQUARE) && ~gate_f[c]) begin
            out_reg <= 1'b1;
          end
          if (fall) begin
            if (armed_reg) begin
              cnt_reg   <= init_reg;
              armed_reg <= 1'b0;
              pend_reg  <= 1'b0;
              run_reg   <= 1'b1;
              trig_reg  <= 1'b0;
            end else if (run_reg) begin
              case (mode_reg)
                `ITP_MODE_TC_INT: begin
                  if (gate_f[c]) begin
                    cnt_reg <= step1;
                    if (cnt_reg == 16'h0001) begin
                      out_reg <= 1'b1;
                    end
                  end
                end
                `ITP_MODE_ONESHOT, `ITP_MODE_HW_STROBE: begin
                  if (trig_reg) begin
                    cnt_reg  <= init_reg;
                    trig_reg <= 1'b0;
                    out_reg  <= (mode_reg == `ITP_MODE_HW_STROBE);
                  end else begin
                    cnt_reg <= step1;
                    if (cnt_reg == 16'h0001) begin
                      out_reg <= (mode_reg == `ITP_MODE_ONESHOT);
                    end else if (mode_reg == `ITP_MODE_HW_STROBE) begin
                      out_reg <= 1'b1;
                    end
                  end
                end
                `ITP_MODE_RATE, `ITP_MODE_SQUARE: begin
                  if (trig_reg) begin
                    cnt_reg  <= init_reg;
                    trig_reg <= 1'b0;
                  end else if (gate_f[c]) begin
                    if (mode_reg == `ITP_MODE_RATE) begin
                      if (cnt_reg == 16'h0001) begin
                        cnt_reg <= init_reg;
                        out_reg <= 1'b1;
                      end else begin
                        cnt_reg <= step1;
                        out_reg <= ~(cnt_reg == 16'h0002);
                      end
                    end else if (cnt_reg <= 16'h0002) begin
                      cnt_reg <= init_reg;
                      out_reg <= ~out_reg;
                    end else begin
                      cnt_reg <= step2;
                    end
                  end
                end
                `ITP_MODE_SW_STROBE: begin
                  if (gate_f[c]) begin
                    cnt_reg <= step1;
                    out_reg <= ~(cnt_reg == 16'h0001);
                  end
                end
                default: cnt_reg <= cnt_reg;
              endcase
            end
          end
          // Gate edge set wins over a same-cycle consume
          if (g_rise) begin
            trig_reg <= 1'b1;
          end
          // Host accesses, taking priority over counting state
          if (cw_hit) begin
            if (wdata_reg[`ITP_CW_ORDER_HI:`ITP_CW_ORDER_LO] ==
                `ITP_ORD_LATCH) begin
              if (~latched_reg) begin
                latch_reg <= cnt_reg;
              end
              latched_reg <= 1'b1;
            end else begin
              mode_reg    <= cw_mode;
              bcd_reg     <= wdata_reg[`ITP_CW_BCD];
              order_reg   <= wdata_reg[`ITP_CW_ORDER_HI:`ITP_CW_ORDER_LO];
              wr_hi_reg   <= 1'b0;
              rd_hi_reg   <= 1'b0;
              latched_reg <= 1'b0;
              run_reg     <= 1'b0;
              pend_reg    <= 1'b0;
              armed_reg   <= 1'b0;
              out_reg     <= (cw_mode != `ITP_MODE_TC_INT);
            end
          end else if (cnt_wr) begin
            case (order_reg)
              `ITP_ORD_LSB: begin
                init_reg <= {8'h00, wdata_reg};
                pend_reg <= 1'b1;
              end
              `ITP_ORD_MSB: begin
                init_reg <= {wdata_reg, 8'h00};
                pend_reg <= 1'b1;
              end
              default: begin
                if (~wr_hi_reg) begin
                  init_reg[7:0] <= wdata_reg;
                  wr_hi_reg     <= 1'b1;
                  if (mode_reg == `ITP_MODE_TC_INT) begin
                    run_reg <= 1'b0;
                  end
                end else begin
                  init_reg[15:8] <= wdata_reg;
                  wr_hi_reg      <= 1'b0;
                  pend_reg       <= 1'b1;
                end
              end
            endcase
            if (mode_reg == `ITP_MODE_TC_INT) begin
              out_reg <= 1'b0;
            end
          end
          if (rd_hit) begin
            if (order_reg == `ITP_ORD_BOTH) begin
              rd_hi_reg <= ~rd_hi_reg;
            end
            if (order_reg != `ITP_ORD_BOTH || rd_hi_reg) begin
              latched_reg <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

endmodule

// ===== itp_properties.sv
/*
  Checker for the interval timer host port.
  Bound to itp_top; sees only its ports.
*/
`timescale 1ns/10ps
module itp_properties (
  input wire       clock,
  input wire       rst,
  input wire       cs_n,
  input wire       rd_n,
  input wire       wr_n,
  input wire       port_select_lo,
  input wire       port_select_hi,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire [2:0] count_clk,
  input wire [2:0] count_gate,
  input wire [2:0] count_out
);
  reg  [3:0] cs_hi_reg;
  reg  [3:0] rd_hi_reg;
  reg  [3:0] ctl_reg;
  reg  [3:0] wr_lo_reg;
  wire [1:0] sel;

  assign sel = {port_select_hi, port_select_lo};

  // Saturating run lengths of idle or refused conditions
  always @(posedge clock) begin
    cs_hi_reg <= (rst || !cs_n) ? 4'h0 : cs_hi_reg + {3'h0, cs_hi_reg != 4'hf};
    rd_hi_reg <= (rst || !rd_n) ? 4'h0 : rd_hi_reg + {3'h0, rd_hi_reg != 4'hf};
    ctl_reg <= (rst || cs_n || sel != 2'h3) ? 4'h0 : ctl_reg + {3'h0, ctl_reg != 4'hf};
    wr_lo_reg <= (rst || wr_n) ? 4'h0 : wr_lo_reg + {3'h0, wr_lo_reg != 4'hf};
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  AST_DESEL_IDLE: assert property (cs_hi_reg >= 4'h6 |-> !data_oe)
    else $error("Data bus driven while deselected");
  AST_NO_STROBE: assert property (rd_hi_reg >= 4'h6 |-> !data_oe)
    else $error("Data bus driven without read strobe");
  AST_CTRL_READ: assert property (ctl_reg >= 4'h6 |-> !data_oe)
    else $error("Data bus driven at control port");
  AST_WRITE_NO_OE: assert property (wr_lo_reg >= 4'h6 |-> !data_oe)
    else $error("Data bus driven during write");
  AST_OE_RISE: assert property ($fell(rd_n) && !cs_n && sel != 2'h3 |-> !data_oe ##[2:6] data_oe)
    else $error("Read did not drive data bus in time");
  AST_OE_HOLD: assert property (data_oe && !rd_n && !cs_n |=> data_oe)
    else $error("Data bus dropped during read");
  AST_OE_FALL: assert property ($rose(rd_n) |-> ##[2:6] !data_oe)
    else $error("Data bus not released after read");
  AST_CW_OUT: assert property ($rose(wr_n) && !cs_n && sel == 2'h3 && data_in[7:6] == 2'h2
    && data_in[5:4] != 2'h0 && data_in[3:1] == 3'h0 |-> ##[2:10] !count_out[2])
    else $error("Mode word did not drive output low");

  ////////////////////////////////////////////////////////////////////////////
  COV_READ: cover property (data_oe [*3]);
  COV_TERM: cover property ($rose(count_out[2]));
  COV_CW: cover property (!cs_n && !wr_n && sel == 2'h3);
endmodule

bind itp_top itp_properties i_props (.clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .port_select_lo(port_select_lo), .port_select_hi(port_select_hi), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .count_clk(count_clk), .count_gate(count_gate),
  .count_out(count_out));

// ===== itp_host_model.sv
/*
  Host bus model: select, strobes, port address, data wire.
  Assumes the 125 MHz clock; device drive wins when data_oe is high.
*/
`timescale 1ns/10ps
module itp_host_model (
  input  wire       clock,
  input  wire [7:0] data_out,
  input  wire       data_oe,
  output reg        cs_n,
  output reg        rd_n,
  output reg        wr_n,
  output reg        port_select_lo,
  output reg        port_select_hi,
  output wire [7:0] data_in
);
  reg       drv;
  reg [7:0] drv_val;
  reg [7:0] last_val;

  // Released wire shows the inverse of the last driven value
  assign data_in = data_oe ? data_out : (drv ? drv_val : ~last_val);

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {port_select_hi, port_select_lo} = 2'h0;
    drv = 1'b0;
    drv_val = 8'h00;
    last_val = 8'h00;
  end

  always @(posedge clock) begin
    if (data_oe === 1'b1 || drv)
      last_val <= data_in;
  end

  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One access: setup 5, strobe 10, hold 6, gap 5 clocks
  task access(input logic sel_n, input logic rd, input logic [1:0] a, input logic [7:0] d,
              output logic [7:0] q, output logic seen);
    begin
      seen = 1'b0;
      cs_n = sel_n;
      {port_select_hi, port_select_lo} = a;
      drv = ~rd;
      drv_val = d;
      tick(5);
      if (rd)
        rd_n = 1'b0;
      else
        wr_n = 1'b0;
      repeat (10) begin
        tick(1);
        if (data_oe === 1'b1)
          seen = 1'b1;
      end
      q = data_out;
      rd_n = 1'b1;
      wr_n = 1'b1;
      tick(6);
      cs_n = 1'b1;
      drv = 1'b0;
      tick(5);
    end
  endtask
endmodule

// ===== tb_top.sv
/*
  Testbench for itp_top with the host bus model.
  Assumes the 125 MHz clock; gates held high except in the rate generator check; modes 0, 4 and 2.
*/
`timescale 1ns/10ps
`include "itp_defines.vh"
module tb_top;
  typedef struct packed {
    logic [1:0]  ch;
    logic [1:0]  ord;
    logic        bcd;
    logic [15:0] val;
    logic [3:0]  np;
    logic [15:0] exp;
  } itp_row_t;

  reg        clock;
  reg        rst;
  reg  [2:0] count_clk;
  reg  [2:0] count_gate;
  wire       cs_n;
  wire       rd_n;
  wire       wr_n;
  wire       port_select_lo;
  wire       port_select_hi;
  wire [7:0] data_in;
  wire [7:0] data_out;
  wire       data_oe;
  wire [2:0] count_out;
  integer    bad_count;
  integer    tests_run;
  integer    cyc;
  integer    i;
  itp_row_t  rows [0:3];
  itp_row_t  r;
  logic [7:0] q;
  logic       s;

  itp_top i_dut (.clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_lo(port_select_lo), .port_select_hi(port_select_hi), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .count_clk(count_clk), .count_gate(count_gate),
    .count_out(count_out));
  itp_host_model i_host (.clock(clock), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_select_lo(port_select_lo), .port_select_hi(port_select_hi),
    .data_in(data_in));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task chk1(input logic got, input logic exp);
    begin
      chk8({7'h00, got}, {7'h00, exp});
    end
  endtask

  task wr(input logic [1:0] a, input logic [7:0] d);
    begin
      i_host.access(1'b0, 1'b0, a, d, q, s);
    end
  endtask

  task rd(input logic [1:0] a);
    begin
      i_host.access(1'b0, 1'b1, a, 8'h00, q, s);
    end
  endtask

  task pulse(input logic [1:0] ch, input logic [3:0] n);
    begin
      repeat (n) begin
        count_clk[ch] = 1'b1;
        i_host.tick(6);
        count_clk[ch] = 1'b0;
        i_host.tick(6);
      end
    end
  endtask

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    rst = 1'b1;
    count_clk = 3'h0;
    count_gate = 3'h7;
    rows[0] = {2'h0, `ITP_ORD_BOTH, 1'b0, 16'h1234, 4'h4, 16'h1231};
    rows[1] = {2'h1, `ITP_ORD_LSB, 1'b0, 16'h0057, 4'h3, 16'h0055};
    rows[2] = {2'h2, `ITP_ORD_MSB, 1'b0, 16'h1200, 4'h2, 16'h11ff};
    rows[3] = {2'h0, `ITP_ORD_BOTH, 1'b1, 16'h0100, 4'h2, 16'h0099};
    i_host.tick(2);
    rst = 1'b0;
    i_host.tick(1);
    chk1(data_oe, 1'b0);
    chk8({5'h00, count_out}, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      r = rows[i];
      wr(`ITP_PORT_CTRL, {r.ch, r.ord, `ITP_MODE_TC_INT, r.bcd});
      if (r.ord != `ITP_ORD_MSB)
        wr(r.ch, r.val[7:0]);
      if (r.ord != `ITP_ORD_LSB)
        wr(r.ch, r.val[15:8]);
      pulse(r.ch, r.np);
      if (r.ord != `ITP_ORD_MSB) begin
        rd(r.ch);
        chk8(q, r.exp[7:0]);
      end
      if (r.ord != `ITP_ORD_LSB) begin
        rd(r.ch);
        chk8(q, r.exp[15:8]);
      end
    end
    rd(`ITP_PORT_CNT1);
    chk8(q, 8'h55);
    // Latch freezes the read value while counting goes on
    wr(`ITP_PORT_CTRL, 8'h00);
    pulse(2'h0, 4'h2);
    rd(`ITP_PORT_CNT0);
    chk8(q, 8'h99);
    rd(`ITP_PORT_CNT0);
    chk8(q, 8'h00);
    rd(`ITP_PORT_CNT0);
    chk8(q, 8'h97);
    rd(`ITP_PORT_CNT0);
    chk8(q, 8'h00);
    // Refused accesses
    i_host.access(1'b1, 1'b0, `ITP_PORT_CNT1, 8'haa, q, s);
    rd(`ITP_PORT_CNT1);
    chk8(q, 8'h55);
    i_host.access(1'b1, 1'b1, `ITP_PORT_CNT1, 8'h00, q, s);
    chk1(s, 1'b0);
    i_host.access(1'b0, 1'b1, `ITP_PORT_CTRL, 8'h00, q, s);
    chk1(s, 1'b0);
    // Mode 0 output on channel 2
    wr(`ITP_PORT_CTRL, {2'h2, `ITP_ORD_LSB, `ITP_MODE_TC_INT, 1'b0});
    wr(`ITP_PORT_CNT2, 8'h02);
    chk1(count_out[2], 1'b0);
    pulse(2'h2, 4'h2);
    chk1(count_out[2], 1'b0);
    pulse(2'h2, 4'h1);
    chk1(count_out[2], 1'b1);
    wr(`ITP_PORT_CTRL, {2'h2, `ITP_ORD_LSB, `ITP_MODE_TC_INT, 1'b0});
    chk1(count_out[2], 1'b0);
    // Software strobe: high after mode set, low one period at terminal count
    wr(`ITP_PORT_CTRL, {2'h1, `ITP_ORD_LSB, `ITP_MODE_SW_STROBE, 1'b0});
    chk1(count_out[1], 1'b1);
    wr(`ITP_PORT_CNT1, 8'h02);
    pulse(2'h1, 4'h3);
    chk1(count_out[1], 1'b0);
    pulse(2'h1, 4'h1);
    chk1(count_out[1], 1'b1);
    // Rate generator: gate low forces the output high
    wr(`ITP_PORT_CTRL, {2'h1, `ITP_ORD_LSB, `ITP_MODE_RATE, 1'b0});
    wr(`ITP_PORT_CNT1, 8'h03);
    pulse(2'h1, 4'h3);
    chk1(count_out[1], 1'b0);
    count_gate[1] = 1'b0;
    i_host.tick(6);
    chk1(count_out[1], 1'b1);
    count_gate[1] = 1'b1;
    i_host.tick(6);
    complete_run;
  end
endmodule
